// ===== logic/sector_protect_lock_logic.sv
// sector protection, lock bit and read-protection logic of the serial flash
//
// Overview of operation
// RL1: unlocked, data 00h clears all sector bits
// RL2: unlocked, data 7Fh sets all sector bits
// RL3: unlocked, data FFh protects all and locks
// RL4: global op decodes only bits 5..2
// RL5: only lock bit stored from status write
// RL6: status bits 4..2 show pin and protection
// RL7: pin high, 0Fh clears lock, no global
// RL8: F0h sets lock, sector bits unchanged
// RL9: pin low and locked freezes lock and sector bits
// RL10: soft lock ignores sector commands, allows unlock
// RL11: unlocking write never applies global op
// RL12: locking write also applies global op
// RL13: pin low lock cleared only by reset
// RL14: host raises pin then unlocks to change
// RL15: read protection is 3Ch plus three address bytes
// RL16: then repeating 00h or FFh per sector
// RL17: chip select release ends read, output off
// RL18: sector bit alone gates program and erase
// RL19: status reports all, some or no protection
// RL20: status write needs write enable latch set
// RL21: reset sets every sector bit to one
// RL22: sector decoded from upper address bits
`timescale 1ns/1ps
module sector_protect_lock_logic (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  input wire logic wp_n_in,
  input wire logic [23:0] pe_addr_in,
  output logic pe_allowed_out,
  output logic [7:0] sector_prot_out,
  output logic sector_lock_bit_out,
  output logic write_enable_latch_out,
  output logic [1:0] software_protect_status_out,
  output logic hw_locked_out
);

  localparam int FRAME_W = sector_protect_pkg::CNT_W + 8 + 8 + 24;
  localparam int STAT_W = sector_protect_pkg::SECTOR_COUNT + 3;

  // ----------------------------------------------------------------
  // spi domain: frame capture
  // ----------------------------------------------------------------
  logic start_reg;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] opcode_reg;
  logic [7:0] data_reg;
  logic [23:0] addr_reg;
  logic [7:0] byte_in;
  logic [5:0] cnt_base;

  // armed by chip select high, consumed by the first clock of a frame
  always_ff @(posedge spi_clk_in or posedge spi_cs_n_in) begin
    if (spi_cs_n_in) begin
      start_reg <= 1'b1;
    end else begin
      start_reg <= 1'b0;
    end
  end

  assign cnt_base = start_reg ? 6'h00 : cnt_reg;
  assign byte_in = {shift_reg[6:0], spi_mosi_in};

  // wrap keeps byte alignment visible after long frames
  always_comb begin
    if (cnt_base == sector_protect_pkg::CNT_WRAP_HI) begin
      cnt_next = sector_protect_pkg::CNT_WRAP_LO;
    end else begin
      cnt_next = cnt_base + 6'h01;
    end
  end

  always_ff @(posedge spi_clk_in) begin
    cnt_reg <= cnt_next;
    shift_reg <= byte_in;
  end

  always_ff @(posedge spi_clk_in) begin
    if (cnt_base[2:0] == 3'h7) begin
      case (cnt_base[5:3])
        3'h0: begin
          opcode_reg <= byte_in;
        end
        3'h1: begin
          data_reg <= byte_in;
          addr_reg[23:16] <= byte_in;
        end
        3'h2: begin
          addr_reg[15:8] <= byte_in;
        end
        3'h3: begin
          addr_reg[7:0] <= byte_in;
        end
        default: begin
          data_reg <= data_reg;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // spi domain: serial output
  // ----------------------------------------------------------------
  logic [STAT_W-1:0] stat_sync;
  logic [7:0] prot_spi;
  logic [7:0] status_byte;
  logic miso_reg;
  logic miso_oe_reg;

  assign prot_spi = stat_sync[7:0];

  always_comb begin
    status_byte = 8'h00;
    status_byte[sector_protect_pkg::ST_LOCK_BIT] = stat_sync[8];
    status_byte[sector_protect_pkg::ST_WP_BIT] = stat_sync[10]; // RL6
    status_byte[sector_protect_pkg::ST_SWP_MSB:sector_protect_pkg::ST_SWP_LSB] =
      sector_protect_pkg::swp_of(prot_spi); // RL6
    status_byte[sector_protect_pkg::ST_WEL_BIT] = stat_sync[9];
  end

  // shifted out on the falling edge, sampled by the host on the rising one
  // chip select high clears the driver at once, so no stale enable opens the next frame
  always_ff @(negedge spi_clk_in or posedge spi_cs_n_in) begin
    if (spi_cs_n_in) begin
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0; // RL17
    end else if (!start_reg && opcode_reg == sector_protect_pkg::OP_READ_PROTECTION &&
        cnt_reg >= sector_protect_pkg::BITS_ADDR) begin // RL15
      miso_reg <= prot_spi[sector_protect_pkg::sector_of(addr_reg)]; // RL16 RL22
      miso_oe_reg <= 1'b1;
    end else if (!start_reg && opcode_reg == sector_protect_pkg::OP_READ_STATUS &&
                 cnt_reg >= sector_protect_pkg::BITS_OPCODE) begin
      miso_reg <= status_byte[~cnt_reg[2:0]];
      miso_oe_reg <= 1'b1;
    end else begin
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
    end
  end

  assign spi_miso_out = miso_reg;
  assign spi_miso_oe_out = miso_oe_reg & ~spi_cs_n_in; // RL17

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  logic [1:0] pin_sync;
  logic [FRAME_W-1:0] frame_sync;
  logic [STAT_W-1:0] stat_core;
  logic [7:0] prot_reg;
  logic lock_reg;
  logic wel_reg;

  sync_2ff #(.WIDTH(2)) u_pin_sync (
    .clk_in(core_clk_in),
    .d_in({spi_cs_n_in, wp_n_in}),
    .q_out(pin_sync)
  );

  // frame words are static while chip select is high
  sync_2ff #(.WIDTH(FRAME_W)) u_frame_sync (
    .clk_in(core_clk_in),
    .d_in({cnt_reg, opcode_reg, data_reg, addr_reg}),
    .q_out(frame_sync)
  );

  // core state into the link clock, settles within two link edges
  assign stat_core = {pin_sync[0], wel_reg, lock_reg, prot_reg};

  sync_2ff #(.WIDTH(STAT_W)) u_stat_sync (
    .clk_in(spi_clk_in),
    .d_in(stat_core),
    .q_out(stat_sync)
  );

  // ----------------------------------------------------------------
  // core domain: command decode at end of frame
  // ----------------------------------------------------------------
  logic cs_prev_reg;
  logic frame_end;
  logic [5:0] f_cnt;
  logic [7:0] f_op;
  logic [7:0] f_data;
  logic [23:0] f_addr;
  logic wp_high;
  logic hw_locked;
  logic aligned;
  logic op_done;
  logic wrsr_go;
  logic sector_go;
  logic [3:0] global_field;

  assign f_cnt = frame_sync[FRAME_W-1 -: 6];
  assign f_op = frame_sync[39:32];
  assign f_data = frame_sync[31:24];
  assign f_addr = frame_sync[23:0];
  assign wp_high = pin_sync[0];
  assign hw_locked = ~wp_high & lock_reg;
  assign frame_end = pin_sync[1] & ~cs_prev_reg;
  assign aligned = (f_cnt[2:0] == 3'h0);
  assign op_done = frame_end & aligned & (f_cnt >= sector_protect_pkg::BITS_OPCODE);
  assign global_field = f_data[sector_protect_pkg::GLOBAL_MSB:sector_protect_pkg::GLOBAL_LSB]; // RL4

  // a refused status write still drops the latch below
  assign wrsr_go = op_done & (f_op == sector_protect_pkg::OP_WRITE_STATUS) &
                   (f_cnt >= sector_protect_pkg::BITS_DATA) &
                   wel_reg & ~hw_locked; // RL20 RL9
  assign sector_go = op_done & (f_cnt >= sector_protect_pkg::BITS_ADDR) &
                     wel_reg & ~lock_reg; // RL10

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      cs_prev_reg <= 1'b1;
    end else begin
      cs_prev_reg <= pin_sync[1];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      wel_reg <= sector_protect_pkg::WEL_RESET;
    end else if (op_done && f_op == sector_protect_pkg::OP_WRITE_ENABLE) begin
      wel_reg <= 1'b1;
    end else if (op_done && (f_op == sector_protect_pkg::OP_WRITE_DISABLE ||
                             f_op == sector_protect_pkg::OP_WRITE_STATUS)) begin
      wel_reg <= 1'b0;
    end else if (frame_end && (f_op == sector_protect_pkg::OP_PROTECT_SECTOR ||
                               f_op == sector_protect_pkg::OP_UNPROTECT_SECTOR) &&
                 f_cnt >= sector_protect_pkg::BITS_OPCODE) begin
      wel_reg <= 1'b0;
    end
  end

  // only bit 7 is stored; reset is the only way out under a low pin
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      lock_reg <= sector_protect_pkg::LOCK_RESET; // RL13
    end else if (wrsr_go) begin
      lock_reg <= f_data[sector_protect_pkg::ST_LOCK_BIT]; // RL5 RL7 RL8 RL3
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      prot_reg <= sector_protect_pkg::PROT_RESET; // RL21
    end else if (wrsr_go && !lock_reg) begin // RL11 RL12
      if (global_field == sector_protect_pkg::GLOBAL_UNPROTECT) begin
        prot_reg <= 8'h00; // RL1
      end else if (global_field == sector_protect_pkg::GLOBAL_PROTECT) begin
        prot_reg <= 8'hff; // RL2 RL3
      end
    end else if (sector_go && f_op == sector_protect_pkg::OP_PROTECT_SECTOR) begin
      prot_reg[sector_protect_pkg::sector_of(f_addr)] <= 1'b1; // RL22
    end else if (sector_go && f_op == sector_protect_pkg::OP_UNPROTECT_SECTOR) begin
      prot_reg[sector_protect_pkg::sector_of(f_addr)] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // core domain: outputs
  // ----------------------------------------------------------------
  logic pe_allowed_reg;
  logic [1:0] swp_reg;
  logic hw_locked_reg;

  // program gate follows the sector bit alone, pin ignored
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      pe_allowed_reg <= 1'b0;
    end else begin
      pe_allowed_reg <= ~prot_reg[sector_protect_pkg::sector_of(pe_addr_in)]; // RL18
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      swp_reg <= sector_protect_pkg::SWP_ALL;
      hw_locked_reg <= 1'b0;
    end else begin
      swp_reg <= sector_protect_pkg::swp_of(prot_reg); // RL19
      hw_locked_reg <= hw_locked;
    end
  end

  assign pe_allowed_out = pe_allowed_reg;
  assign sector_prot_out = prot_reg;
  assign sector_lock_bit_out = lock_reg;
  assign write_enable_latch_out = wel_reg;
  assign software_protect_status_out = swp_reg;
  assign hw_locked_out = hw_locked_reg;

endmodule : sector_protect_lock_logic

// ===== include/sector_protect_pkg.sv
// constants and helpers shared by the sector protection logic
package sector_protect_pkg;

  // ----------------------------------------------------------------
  // serial opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_PROTECT_SECTOR = 8'h36;
  localparam logic [7:0] OP_UNPROTECT_SECTOR = 8'h39;
  localparam logic [7:0] OP_READ_PROTECTION = 8'h3c;

  // ----------------------------------------------------------------
  // sector map
  // ----------------------------------------------------------------
  localparam int SECTOR_COUNT = 8;
  localparam int SECTOR_IDX_W = 3;
  localparam int SECTOR_LSB = 16;
  localparam int SECTOR_MSB = 18;

  // ----------------------------------------------------------------
  // frame bit counts
  // ----------------------------------------------------------------
  localparam int CNT_W = 6;
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_DATA = 6'h10;
  localparam logic [5:0] BITS_ADDR = 6'h20;
  localparam logic [5:0] CNT_WRAP_LO = 6'h28;
  localparam logic [5:0] CNT_WRAP_HI = 6'h2f;

  // ----------------------------------------------------------------
  // status byte layout and write-data fields
  // ----------------------------------------------------------------
  localparam int ST_LOCK_BIT = 7;
  localparam int ST_WP_BIT = 4;
  localparam int ST_SWP_MSB = 3;
  localparam int ST_SWP_LSB = 2;
  localparam int ST_WEL_BIT = 1;
  localparam int GLOBAL_MSB = 5;
  localparam int GLOBAL_LSB = 2;
  localparam logic [3:0] GLOBAL_UNPROTECT = 4'h0;
  localparam logic [3:0] GLOBAL_PROTECT = 4'hf;
  localparam logic [1:0] SWP_NONE = 2'h0;
  localparam logic [1:0] SWP_SOME = 2'h1;
  localparam logic [1:0] SWP_ALL = 2'h3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [SECTOR_COUNT-1:0] PROT_RESET = 8'hff;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic WEL_RESET = 1'b0;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [SECTOR_IDX_W-1:0] sector_of(input logic [23:0] addr);
    return addr[SECTOR_MSB:SECTOR_LSB];
  endfunction : sector_of

  function automatic logic [1:0] swp_of(input logic [SECTOR_COUNT-1:0] prot);
    if (&prot) begin
      return SWP_ALL;
    end else if (|prot) begin
      return SWP_SOME;
    end
    return SWP_NONE;
  endfunction : swp_of

endpackage : sector_protect_pkg

// ===== logic/sync_2ff.sv
// two flip-flop synchroniser for levels and quasi-static words
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk_in) begin
    meta_reg <= d_in;
    sync_reg <= meta_reg;
  end

  assign q_out = sync_reg;

endmodule : sync_2ff

// ===== test/sector_protect_props.sv
// concurrent checks on the sector protection ports
`timescale 1ns/1ps
module sector_protect_props (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_miso_oe_out,
  input wire logic [23:0] pe_addr_in,
  input wire logic pe_allowed_out,
  input wire logic [7:0] sector_prot_out,
  input wire logic sector_lock_bit_out,
  input wire logic write_enable_latch_out,
  input wire logic [1:0] software_protect_status_out,
  input wire logic hw_locked_out
);
  logic run_reg;
  logic [2:0] sec_reg;
  always_ff @(posedge core_clk_in) begin
    run_reg <= nrst_in;
    sec_reg <= pe_addr_in[18:16];
  end
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);
  a_oe_cs_off: assert property (spi_cs_n_in |-> !spi_miso_oe_out)
    else $error("output enabled with chip select high");
  a_hw_lock_frozen: assert property (hw_locked_out |=> $stable(sector_lock_bit_out))
    else $error("lock bit moved under hardware lock");
  a_prot_frozen: assert property (sector_lock_bit_out |=> $stable(sector_prot_out))
    else $error("sector bits moved while locked");
  a_wel_needed: assert property ($changed(sector_prot_out) || $changed(sector_lock_bit_out) |-> $past(write_enable_latch_out))
    else $error("protection changed without write enable");
  a_wel_cleared: assert property ($changed(sector_prot_out) |-> !write_enable_latch_out)
    else $error("write enable kept after update");
  a_swp_summary: assert property ($stable(sector_prot_out) |-> software_protect_status_out == ((&sector_prot_out) ? 2'h3 : ((|sector_prot_out) ? 2'h1 : 2'h0)))
    else $error("summary status wrong");
  a_pe_gate: assert property (run_reg && $stable(sector_prot_out) |-> pe_allowed_out == !sector_prot_out[sec_reg])
    else $error("program gate wrong");
  a_hw_needs_lock: assert property (hw_locked_out |-> sector_lock_bit_out)
    else $error("hardware lock without lock bit");
endmodule : sector_protect_props

// ===== test/spi_host_model.sv
// spi host driving frames into the protection logic
`timescale 1ns/1ps
module spi_host_model (
  output logic spi_clk_out,
  output logic spi_cs_n_out,
  output logic spi_mosi_out,
  input wire logic spi_miso_in,
  input wire logic spi_miso_oe_in
);
  logic so;
  // undriven output is not trusted
  assign so = spi_miso_oe_in ? spi_miso_in : ~spi_clk_out;
  // one rising chip select edge arms the frame logic, which has no reset
  initial begin
    spi_clk_out = 1'h0;
    spi_cs_n_out = 1'h0;
    spi_mosi_out = 1'h0;
    #2;
    spi_cs_n_out = 1'h1;
  end
  // msb first, clock runs only inside a frame
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    spi_cs_n_out = 1'h0;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi_out = (i < 32) ? tx[31 - i] : ~spi_mosi_out;
      #7.5;
      spi_clk_out = 1'h1;
      rx = {rx[6:0], so};
      #7.5;
      spi_clk_out = 1'h0;
    end
    #7;
    spi_cs_n_out = 1'h1;
    spi_mosi_out = ~spi_mosi_out;
    #90;
  endtask : xfer
endmodule : spi_host_model

// ===== test/testbench.sv
// self-checking bench for the sector protection logic
`timescale 1ns/1ps
module testbench;
  logic clk, nrst, wp_n, sclk, cs_n, mosi, miso, oe, pe_ok, lock, write_enable_latch, hwl, lk_m;
  logic [23:0] pe_addr;
  logic [7:0] prot, p_m, rx;
  logic [1:0] software_protect_status;
  logic [31:0] lfsr = 32'h6c15_a537;
  logic [8:0] corner [12] = '{9'h100, 9'h1f0, 9'h13c, 9'h17f, 9'h143, 9'h1bc, 9'h10f, 9'h100, 9'h1ff, 9'h10f,
    9'h0f0, 9'h000};
  int fails = 0;
  int n_tests = 0;
  sector_protect_lock_logic i_sector_protect_lock_logic (.core_clk_in(clk), .nrst_in(nrst),
    .spi_clk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .spi_miso_oe_out(oe), .wp_n_in(wp_n), .pe_addr_in(pe_addr), .pe_allowed_out(pe_ok),
    .sector_prot_out(prot), .sector_lock_bit_out(lock), .write_enable_latch_out(write_enable_latch),
    .software_protect_status_out(software_protect_status), .hw_locked_out(hwl));
  spi_host_model i_spi_host_model (.spi_clk_out(sclk), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi),
    .spi_miso_in(miso), .spi_miso_oe_in(oe));
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd
  function automatic logic [1:0] swp_exp(input logic [7:0] p);
    return (&p) ? 2'h3 : ((|p) ? 2'h1 : 2'h0);
  endfunction : swp_exp
  function automatic logic [8:0] sw_next(input logic wp, input logic lk, input logic [7:0] p, input logic [7:0] d);
    if (lk && !wp) return {lk, p};
    if (lk) return {d[7], p};
    if (d[5:2] == 4'h0) p = 8'h00;
    else if (d[5:2] == 4'hf) p = 8'hff;
    return {d[7], p};
  endfunction : sw_next
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic st_chk();
    tick(1);
    check(prot, p_m, "sector bits");
    check(lock, lk_m, "lock bit");
    check(write_enable_latch, 1'h0, "latch left set");
    check(software_protect_status, swp_exp(p_m), "summary");
    check(hwl, lk_m & ~wp_n, "hw lock");
    i_spi_host_model.xfer({8'h05, 24'h0}, 16, rx);
    check(rx, {lk_m, 2'h0, wp_n, swp_exp(p_m), 2'h0}, "status byte");
    tick(1);
  endtask : st_chk
  task automatic wsr(input logic [7:0] d, input logic en);
    if (en) begin
      i_spi_host_model.xfer({8'h06, 24'h0}, 8, rx);
      tick(1);
      check(write_enable_latch, 1'h1, "latch not set");
    end
    i_spi_host_model.xfer({8'h01, d, 16'h0}, 16, rx);
    if (en) {lk_m, p_m} = sw_next(wp_n, lk_m, p_m, d);
    st_chk();
  endtask : wsr
  task automatic sec(input logic [7:0] op, input logic [2:0] s);
    i_spi_host_model.xfer({8'h06, 24'h0}, 8, rx);
    i_spi_host_model.xfer({op, lfsr[4:0], s, 16'h0}, 32, rx);
    if (!lk_m) p_m[s] = (op == 8'h36);
    st_chk();
  endtask : sec
  task automatic rdp();
    for (int s = 0; s < 8; s++) begin
      tick(1);
      lfsr = rnd(lfsr);
      pe_addr = {lfsr[20:16], s[2:0], lfsr[15:0]};
      i_spi_host_model.xfer({8'h3c, pe_addr}, 48, rx);
      check(rx, {8{p_m[s]}}, "read protection");
      check(pe_ok, !p_m[s], "program gate");
    end
    tick(1);
    $display("read protection pass done");
  endtask : rdp
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    nrst = 1'h0;
    wp_n = 1'h1;
    pe_addr = 24'h00_0000;
    p_m = 8'hff;
    lk_m = 1'h0;
    tick(5);
    nrst = 1'h1;
    tick(4);
    st_chk();
    foreach (corner[k]) begin
      wp_n = corner[k][8];
      tick(4);
      wsr(corner[k][7:0], 1'h1);
    end
    sec(8'h39, 3'h3);
    rdp();
    i_spi_host_model.xfer({8'h3c, 24'h0}, 37, rx);
    check(oe, 1'h0, "output left on");
    $display("corner cases done");
    tick(1);
    nrst = 1'h0;
    tick(2);
    nrst = 1'h1;
    p_m = 8'hff;
    lk_m = 1'h0;
    tick(4);
    st_chk();
    $display("reset release done");
    for (int i = 0; i < 40; i++) begin
      lfsr = rnd(lfsr);
      wp_n = lfsr[8] | lfsr[13];
      tick(4);
      if (lfsr[10:9] == 2'h0) sec(lfsr[11] ? 8'h36 : 8'h39, lfsr[16:14]);
      else wsr(lfsr[7:0], lfsr[12] | lfsr[17]);
      if (i % 10 == 9) rdp();
    end
    $display("random traffic done");
    give_verdict();
  end
endmodule : testbench
bind sector_protect_lock_logic sector_protect_props i_sector_protect_props (.core_clk_in(core_clk_in),
  .nrst_in(nrst_in), .spi_cs_n_in(spi_cs_n_in), .spi_miso_oe_out(spi_miso_oe_out), .pe_addr_in(pe_addr_in),
  .pe_allowed_out(pe_allowed_out), .sector_prot_out(sector_prot_out), .sector_lock_bit_out(sector_lock_bit_out),
  .write_enable_latch_out(write_enable_latch_out), .software_protect_status_out(software_protect_status_out),
  .hw_locked_out(hw_locked_out));
